// ---- pkg/rbc_consts.svh ----
// register offsets, field positions, reset values and counts of the radio control bank
`ifndef RBC_CONSTS_SVH
`define RBC_CONSTS_SVH

// =====================================================================
// register offsets
`define RBC_ADDR_SYNTH_A 6'h01
`define RBC_ADDR_SYNTH_N 6'h02
`define RBC_ADDR_CONTROL 6'h03
`define RBC_ADDR_RATE 6'h04
`define RBC_ADDR_CONFIG 6'h05
`define RBC_ADDR_SER_CTL 6'h06
`define RBC_ADDR_RX_STATUS 6'h08
`define RBC_ADDR_RX_DATA 6'h09
`define RBC_ADDR_RX_VALID 6'h0A
`define RBC_ADDR_TX_DATA 6'h0F
`define RBC_ADDR_CHANNEL 6'h21

// =====================================================================
// reset values
`define RBC_RST_SYNTH_A 5'h00
`define RBC_RST_SYNTH_N 7'h00
`define RBC_RST_CONTROL 8'h00
`define RBC_RST_RATE 3'h0
`define RBC_RST_CONFIG 8'h01
`define RBC_RST_SER_CTL 4'h3
`define RBC_RST_CHANNEL 8'h00

// =====================================================================
// field positions
`define RBC_CHAN_SEL_BIT 7
`define RBC_RATE_CODE32_BIT 2
`define RBC_RATE_DDR_BIT 1
`define RBC_RATE_OSR12_BIT 0
`define RBC_CFG_RX_INV_BIT 4
`define RBC_CFG_TX_INV_BIT 3
`define RBC_SER_EN_BIT 3
`define RBC_STAT_NONEMPTY_BIT 0
`define RBC_STAT_EOF_BIT 1
`define RBC_STAT_FLOW_BIT 2

// =====================================================================
// irq pin drive styles
`define RBC_IRQ_OPEN_SOURCE 2'h3
`define RBC_IRQ_OPEN_DRAIN 2'h2
`define RBC_IRQ_PUSH_HIGH 2'h1
`define RBC_IRQ_PUSH_LOW 2'h0

// =====================================================================
// channel to divider mapping: total count = base + channel, A = low 5 bits
`define RBC_SYNTH_BASE 12'h940
`define RBC_RX_FIFO_DEPTH 8

`endif

// ---- pkg/rbc_pkg.sv ----
// types shared by the radio control bank
package rbc_pkg;

  // =====================================================================
  // control register fields, msb first
  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic code_half;
    logic settle_src;
    logic amp_manual;
    logic amp_on;
    logic synth_manual;
    logic synth_on;
  } rbc_ctrl_s;

  // =====================================================================
  // synthesizer divider pair
  typedef struct packed {
    logic [6:0] n_count;
    logic [4:0] a_count;
  } rbc_synth_s;

  // =====================================================================
  // one received byte with its per-bit valid mask
  typedef struct packed {
    logic [7:0] valid;
    logic [7:0] data;
  } rbc_rx_word_s;

  // =====================================================================
  // steering handed to the rf and correlator logic
  typedef struct packed {
    logic rx_mode;
    logic tx_mode;
    logic synth_on;
    logic settle_src;
    logic amp_on;
    logic code_half;
    logic code32;
    logic ddr;
    logic osr12;
    logic dual_code;
    logic rate_invalid;
  } rbc_radio_s;

endpackage : rbc_pkg

// ---- design/rbc_fifo.sv ----
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module rbc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic in_valid, // write request
  output logic in_ready, // room available
  input wire logic [WIDTH-1:0] in_data, // write word
  output logic out_valid, // word available
  input wire logic out_ready, // read acknowledge
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [PW:0] count_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count_q != FULL_CNT);
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == LAST_PTR) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == LAST_PTR) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  // storage has no reset: contents are only seen behind out_valid
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end
endmodule : rbc_fifo

// ---- design/rbc_regs.sv ----
// control register bank of the spread-spectrum radio baseband
// Behaviour
// - channel bit 7 picks channel or dividers
// - channel mode: divider reads show derived values
// - 12x oversampling drops dual-code receive
// - serializer bit 3 picks byte or pin path
// - serializer moves one byte per access
// - eof length counts idle bit times
// - eof armed in receive after valid bit
// - eof flushes partial byte to receive data
// - length zero ends at first invalid bit
`timescale 1ns/1ps
`include "rbc_consts.svh"
module rbc_regs #(
  parameter int FIFO_DEPTH = `RBC_RX_FIFO_DEPTH
) (
  input wire logic clk_sys, // system clock, 40 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [5:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, valid cycle after reg_rd
  input wire logic bit_tick, // one pulse per over-the-air bit time
  input wire logic rx_bit, // correlated receive bit
  input wire logic rx_bit_valid, // receive bit correlated
  output logic tx_bit, // transmit bit to modulator
  output logic tx_bit_valid, // transmit bit present
  input wire logic auto_synth_req, // sequencer synth request
  input wire logic auto_amp_req, // sequencer amplifier request
  input wire logic irq_req, // combined interrupt request
  output logic irq_pin_o, // irq pin level
  output logic irq_pin_oe, // irq pin drive enable
  input wire logic direct_bit_data_i, // data pin input
  output logic direct_bit_data_o, // data pin output
  output logic direct_bit_data_oe, // data pin drive enable
  input wire logic direct_bit_valid_i, // valid pin input
  output logic direct_bit_valid_o, // valid pin output
  output logic direct_bit_valid_oe, // valid pin drive enable
  output rbc_pkg::rbc_synth_s synth_div, // dividers applied to synth
  output rbc_pkg::rbc_radio_s radio, // mode steering
  output logic eof_event // one-cycle end-of-frame pulse
);
  import rbc_pkg::*;

  // =====================================================================
  // registers
  logic [4:0] synth_a_q;
  logic [6:0] synth_n_q;
  rbc_ctrl_s ctrl_q;
  logic [2:0] rate_q;
  logic [2:0] cfg_q;
  logic [1:0] irq_style_q;
  logic [3:0] ser_q;
  logic [7:0] chan_q;
  logic [2:0] stat_q;
  logic [7:0] rdata_q;

  // =====================================================================
  // decode
  wire wr_a = reg_wr && (reg_addr == `RBC_ADDR_SYNTH_A);
  wire wr_n = reg_wr && (reg_addr == `RBC_ADDR_SYNTH_N);
  wire wr_ctrl = reg_wr && (reg_addr == `RBC_ADDR_CONTROL);
  wire wr_rate = reg_wr && (reg_addr == `RBC_ADDR_RATE);
  wire wr_cfg = reg_wr && (reg_addr == `RBC_ADDR_CONFIG);
  wire wr_ser = reg_wr && (reg_addr == `RBC_ADDR_SER_CTL);
  wire wr_chan = reg_wr && (reg_addr == `RBC_ADDR_CHANNEL);
  wire wr_tx = reg_wr && (reg_addr == `RBC_ADDR_TX_DATA);
  wire rd_stat = reg_rd && (reg_addr == `RBC_ADDR_RX_STATUS);
  wire rd_data = reg_rd && (reg_addr == `RBC_ADDR_RX_DATA);
  wire chan_mode = !chan_q[`RBC_CHAN_SEL_BIT];
  wire serdes_en = ser_q[`RBC_SER_EN_BIT];
  wire [2:0] eof_len = ser_q[2:0];
  wire rx_inv = cfg_q[1];
  wire tx_inv = cfg_q[0];

  // channel maps to a divider total; A is the low five bits
  wire [11:0] chan_total = `RBC_SYNTH_BASE + {5'h00, chan_q[6:0]};
  wire [4:0] chan_a = chan_total[4:0];
  wire [6:0] chan_n = chan_total[11:5];
  wire [4:0] eff_a = chan_mode ? chan_a : synth_a_q;
  wire [6:0] eff_n = chan_mode ? chan_n : synth_n_q;

  // =====================================================================
  // register writes, reserved bits dropped
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      synth_a_q <= `RBC_RST_SYNTH_A;
      synth_n_q <= `RBC_RST_SYNTH_N;
      ctrl_q <= `RBC_RST_CONTROL;
      rate_q <= `RBC_RST_RATE;
      {cfg_q, irq_style_q} <= {3'(`RBC_RST_CONFIG >> 2), 2'(`RBC_RST_CONFIG)};
      ser_q <= `RBC_RST_SER_CTL;
      chan_q <= `RBC_RST_CHANNEL;
    end else begin
      if (wr_a) synth_a_q <= reg_wdata[4:0];
      if (wr_n) synth_n_q <= reg_wdata[6:0];
      if (wr_ctrl) ctrl_q <= reg_wdata;
      if (wr_rate) rate_q <= reg_wdata[2:0];
      if (wr_cfg) {cfg_q, irq_style_q} <= {1'b0, reg_wdata[4:3], reg_wdata[1:0]};
      if (wr_ser) ser_q <= reg_wdata[3:0];
      if (wr_chan) chan_q <= reg_wdata;
    end
  end

  // =====================================================================
  // radio steering
  wire code32 = rate_q[`RBC_RATE_CODE32_BIT];
  wire ddr = code32 && rate_q[`RBC_RATE_DDR_BIT];
  wire osr12 = code32 && !ddr && rate_q[`RBC_RATE_OSR12_BIT];
  wire rate_bad = rate_q inside {3'h1, 3'h2, 3'h3, 3'h7};
  rbc_radio_s radio_d;
  always_comb begin
    radio_d.rx_mode = ctrl_q.rx_en;
    radio_d.tx_mode = ctrl_q.tx_en;
    radio_d.synth_on = ctrl_q.synth_manual ? ctrl_q.synth_on : auto_synth_req;
    radio_d.settle_src = ctrl_q.settle_src;
    radio_d.amp_on = ctrl_q.amp_manual ? ctrl_q.amp_on : auto_amp_req;
    radio_d.code_half = ctrl_q.code_half;
    radio_d.code32 = code32;
    radio_d.ddr = ddr;
    radio_d.osr12 = osr12;
    radio_d.dual_code = code32 && !ddr && !osr12;
    radio_d.rate_invalid = rate_bad;
  end
  // open styles (1x) drive the irq pin only while the request stands
  wire irq_o_d = irq_style_q[1] ? irq_style_q[0] : (irq_req ~^ irq_style_q[0]);
  wire irq_oe_d = irq_style_q[1] ? irq_req : 1'b1;
  rbc_radio_s radio_q;
  rbc_synth_s synth_q;
  logic irq_o_q;
  logic irq_oe_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      radio_q <= '0;
      synth_q <= '0;
      {irq_o_q, irq_oe_q} <= 2'h0;
    end else begin
      radio_q <= radio_d;
      synth_q <= '{n_count: eff_n, a_count: eff_a};
      irq_o_q <= irq_o_d;
      irq_oe_q <= irq_oe_d;
    end
  end

  // =====================================================================
  // receive assembly and end-of-frame
  wire rx_b = rx_bit ^ rx_inv;
  wire rx_run = radio_q.rx_mode && serdes_en && bit_tick;
  logic [7:0] asm_data_q;
  logic [7:0] asm_valid_q;
  logic [2:0] asm_cnt_q;
  logic asm_any_q;
  logic armed_q;
  logic [2:0] idle_q;
  logic push_q;
  rbc_rx_word_s push_word_q;
  logic eof_q;

  wire eof_hit = rx_run && armed_q && !rx_bit_valid && (idle_q == eof_len);
  wire take_bit = rx_run && (rx_bit_valid || armed_q) && !eof_hit;
  wire [7:0] bit_sel = 8'h01 << asm_cnt_q;
  wire [7:0] nxt_data = rx_b ? (asm_data_q | bit_sel) : (asm_data_q & ~bit_sel);
  wire [7:0] nxt_valid = rx_bit_valid ? (asm_valid_q | bit_sel) : asm_valid_q;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {asm_data_q, asm_valid_q, asm_cnt_q, asm_any_q} <= 20'h00000;
      {armed_q, idle_q, push_q, eof_q} <= 6'h00;
      push_word_q <= '0;
    end else begin
      push_q <= 1'b0;
      eof_q <= eof_hit;
      if (!radio_q.rx_mode) begin
        armed_q <= 1'b0;
      end else if (rx_run && rx_bit_valid) begin
        armed_q <= 1'b1;
        idle_q <= 3'h0;
      end else if (rx_run && armed_q && !eof_hit) begin
        idle_q <= idle_q + 3'h1;
      end
      if (eof_hit) begin
        armed_q <= 1'b0;
        idle_q <= 3'h0;
        asm_cnt_q <= 3'h0;
        asm_any_q <= 1'b0;
        asm_valid_q <= 8'h00;
        push_q <= asm_any_q && (asm_valid_q != 8'h00); // gap bits alone carry no data
        push_word_q <= '{valid: asm_valid_q, data: asm_data_q};
      end else if (take_bit) begin
        asm_cnt_q <= asm_cnt_q + 3'h1;
        if (asm_cnt_q == 3'h7) begin
          push_q <= 1'b1;
          push_word_q <= '{valid: nxt_valid, data: nxt_data};
          asm_any_q <= 1'b0;
          asm_valid_q <= 8'h00;
        end else begin
          asm_any_q <= 1'b1;
          asm_data_q <= nxt_data;
          asm_valid_q <= nxt_valid;
        end
      end
    end
  end

  // =====================================================================
  // receive fifo, drained one byte per data read
  logic fifo_in_ready;
  logic fifo_out_valid;
  rbc_rx_word_s fifo_head;
  wire pop = rd_data && fifo_out_valid;

  rbc_fifo #(
    .WIDTH($bits(rbc_rx_word_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(push_q),
    .in_ready(fifo_in_ready),
    .in_data(push_word_q),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_head)
  );

  // overflow when fifo refuses a byte, underflow on empty read; set beats clear
  wire flow_set = (push_q && !fifo_in_ready) || (rd_data && !fifo_out_valid);
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= 3'h0;
    end else begin
      stat_q[`RBC_STAT_NONEMPTY_BIT] <= fifo_out_valid;
      stat_q[`RBC_STAT_EOF_BIT] <= eof_q || (stat_q[`RBC_STAT_EOF_BIT] && !rd_stat);
      stat_q[`RBC_STAT_FLOW_BIT] <= flow_set || (stat_q[`RBC_STAT_FLOW_BIT] && !rd_stat);
    end
  end

  // =====================================================================
  // transmit serializer and direct pins
  logic [7:0] tx_shift_q;
  logic [3:0] tx_left_q;
  logic tx_bit_q;
  logic tx_val_q;
  logic dio_d_q;
  logic dio_v_q;
  logic dio_oe_q;
  wire tx_tick = radio_q.tx_mode && bit_tick;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {tx_shift_q, tx_left_q} <= 12'h000;
      {tx_bit_q, tx_val_q, dio_d_q, dio_v_q, dio_oe_q} <= 5'h00;
    end else begin
      dio_oe_q <= ctrl_q.rx_en && !serdes_en;
      if (wr_tx && serdes_en && (tx_left_q == 4'h0)) begin
        tx_shift_q <= reg_wdata;
        tx_left_q <= 4'h8;
      end else if (tx_tick && serdes_en && (tx_left_q != 4'h0)) begin
        tx_shift_q <= {1'b0, tx_shift_q[7:1]};
        tx_left_q <= tx_left_q - 4'h1;
      end
      if (tx_tick) begin
        if (serdes_en) begin
          tx_bit_q <= tx_shift_q[0] ^ tx_inv;
          tx_val_q <= (tx_left_q != 4'h0);
        end else begin
          tx_bit_q <= direct_bit_data_i ^ tx_inv;
          tx_val_q <= direct_bit_valid_i;
        end
      end
      if (radio_q.rx_mode && bit_tick) begin
        dio_d_q <= rx_b;
        dio_v_q <= rx_bit_valid;
      end
    end
  end

  // =====================================================================
  // read mux
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `RBC_ADDR_SYNTH_A: rd_mux = {3'h0, eff_a};
      `RBC_ADDR_SYNTH_N: rd_mux = {1'b0, eff_n};
      `RBC_ADDR_CONTROL: rd_mux = ctrl_q;
      `RBC_ADDR_RATE: rd_mux = {5'h00, rate_q};
      `RBC_ADDR_CONFIG: rd_mux = {3'h0, cfg_q[1:0], 1'b0, irq_style_q};
      `RBC_ADDR_SER_CTL: rd_mux = {4'h0, ser_q};
      `RBC_ADDR_RX_STATUS: rd_mux = {5'h00, stat_q};
      `RBC_ADDR_RX_DATA: rd_mux = fifo_out_valid ? fifo_head.data : 8'h00;
      `RBC_ADDR_RX_VALID: rd_mux = fifo_out_valid ? fifo_head.valid : 8'h00;
      `RBC_ADDR_CHANNEL: rd_mux = chan_q;
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rd_mux;
    end
  end

  // =====================================================================
  // outputs
  assign reg_rdata = rdata_q;
  assign tx_bit = tx_bit_q;
  assign tx_bit_valid = tx_val_q;
  assign irq_pin_o = irq_o_q;
  assign irq_pin_oe = irq_oe_q;
  assign direct_bit_data_o = dio_d_q;
  assign direct_bit_data_oe = dio_oe_q;
  assign direct_bit_valid_o = dio_v_q;
  assign direct_bit_valid_oe = dio_oe_q;
  assign synth_div = synth_q;
  assign radio = radio_q;
  assign eof_event = eof_q;
endmodule : rbc_regs

// ---- tb/rbc_host_model.sv ----
// host side register access model
`timescale 1ns/1ps
module rbc_host_model (
  input wire logic clk_sys, // clock
  output logic reg_wr, // write strobe
  output logic reg_rd, // read strobe
  output logic [5:0] reg_addr, // address
  output logic [7:0] reg_wdata, // write data
  input wire logic [7:0] reg_rdata // read data
);
  // ====
  // idle bus shows inverted leftovers so stale values never look valid
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 16'h3FA5;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
    @(posedge clk_sys);
  endtask : rd
endmodule : rbc_host_model

// ---- tb/rbc_regs_chk.sv ----
// port checks of the radio control bank
`timescale 1ns/1ps
`include "rbc_consts.svh"
module rbc_regs_chk (
  input wire logic clk_sys, // clock
  input wire logic arst_n, // reset
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic [5:0] reg_addr, // address
  input wire logic [7:0] reg_wdata, // wdata
  input wire logic [7:0] reg_rdata, // rdata
  input wire logic bit_tick, // bit time
  input wire logic rx_bit_valid, // rx valid
  input wire logic auto_synth_req, // seq synth
  input wire logic auto_amp_req, // seq amp
  input wire logic irq_req, // irq cause
  input wire logic irq_pin_o, // irq level
  input wire logic irq_pin_oe, // irq enable
  input wire logic direct_bit_data_oe, // pin enable
  input wire rbc_pkg::rbc_synth_s synth_div, // dividers
  input wire rbc_pkg::rbc_radio_s radio, // steering
  input wire logic eof_event // frame end
);
  import rbc_pkg::*;
  // ====
  // shadow registers, reserved bits dropped
  logic [7:0] ctl_q, cfg_q, ch_q;
  logic [3:0] ser_q;
  logic [2:0] rate_q, idle_q;
  logic [4:0] a_q;
  logic [6:0] n_q;
  logic rdy_q, arm_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {ctl_q, cfg_q, ch_q, ser_q, rate_q, a_q, n_q} <= {16'h0001, 8'h00, 4'h3, 15'h0000};
    end else if (reg_wr) begin
      case (reg_addr)
        `RBC_ADDR_CONTROL: ctl_q <= reg_wdata;
        `RBC_ADDR_CONFIG: cfg_q <= reg_wdata & 8'h1B;
        `RBC_ADDR_CHANNEL: ch_q <= reg_wdata;
        `RBC_ADDR_SER_CTL: ser_q <= reg_wdata[3:0];
        `RBC_ADDR_RATE: rate_q <= reg_wdata[2:0];
        `RBC_ADDR_SYNTH_A: a_q <= reg_wdata[4:0];
        `RBC_ADDR_SYNTH_N: n_q <= reg_wdata[6:0];
        default: ;
      endcase
    end
  end
  // ====
  // frame gap tracking; first edge after reset is skipped via rdy_q
  wire rx_on_w = ctl_q[7] && ser_q[3];
  wire eof_w = bit_tick && rx_on_w && arm_q && !rx_bit_valid && idle_q == ser_q[2:0];
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      {rdy_q, arm_q, idle_q} <= 5'h00;
    end else begin
      rdy_q <= 1'b1;
      if (bit_tick && rx_on_w) begin
        arm_q <= rx_bit_valid || (arm_q && !eof_w);
        idle_q <= rx_bit_valid ? 3'h0 : idle_q + 3'h1;
      end
    end
  end
  wire [11:0] tot_w = `RBC_SYNTH_BASE + {5'h00, ch_q[6:0]};
  wire [11:0] syn_w = ch_q[`RBC_CHAN_SEL_BIT] ? {n_q, a_q} : tot_w;
  wire syn_on_w = ctl_q[1] ? ctl_q[0] : auto_synth_req;
  wire amp_on_w = ctl_q[3] ? ctl_q[2] : auto_amp_req;
  wire irq_oe_w = cfg_q[1] ? irq_req : 1'b1;
  wire irq_o_w = cfg_q[1] ? cfg_q[0] : (irq_req ~^ cfg_q[0]);
  wire pin_oe_w = ctl_q[7] && !ser_q[3];
  wire rd_known_w = !(reg_addr inside {6'h08, 6'h09, 6'h0A, 6'h0F, 6'h21});
  wire [7:0] rd_exp_w = reg_addr == `RBC_ADDR_SYNTH_A ? {3'h0, syn_w[4:0]} :
    reg_addr == `RBC_ADDR_SYNTH_N ? {1'h0, syn_w[11:5]} :
    reg_addr == `RBC_ADDR_CONTROL ? ctl_q : reg_addr == `RBC_ADDR_RATE ? {5'h00, rate_q} :
    reg_addr == `RBC_ADDR_CONFIG ? cfg_q : reg_addr == `RBC_ADDR_SER_CTL ? {4'h0, ser_q} : 8'h00;
  // ====
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_ctl_write;
    reg_wr && reg_addr == `RBC_ADDR_CONTROL;
  endsequence
  sequence s_gap_end;
    eof_w;
  endsequence
  a_mode_bits_follow: assert property (s_ctl_write |=> ##1
    {radio.rx_mode, radio.tx_mode} == $past(reg_wdata[7:6], 2)) else $error("mode bits wrong");
  a_synth_ctrl_src: assert property (rdy_q |-> radio.synth_on == $past(syn_on_w))
    else $error("synth enable source wrong");
  a_amp_ctrl_src: assert property (rdy_q |-> radio.amp_on == $past(amp_on_w))
    else $error("amp enable source wrong");
  a_dual_code_drop: assert property ((radio.osr12 || radio.dual_code) |-> radio.code32 &&
    !radio.ddr && !(radio.osr12 && radio.dual_code)) else $error("dual code with 12x");
  a_irq_pin_drive: assert property (rdy_q |-> irq_pin_oe == $past(irq_oe_w) &&
    (!irq_pin_oe || irq_pin_o == $past(irq_o_w))) else $error("irq pin drive wrong");
  a_synth_div_src: assert property (rdy_q |-> synth_div == $past(syn_w))
    else $error("divider source wrong");
  a_eof_on_gap: assert property (s_gap_end |=> eof_event)
    else $error("frame end missed");
  a_eof_only_armed: assert property (eof_event |-> $past(eof_w))
    else $error("frame end unexpected");
  a_rdata_value: assert property (reg_rd && rd_known_w |=> reg_rdata == $past(rd_exp_w))
    else $error("read data wrong");
  a_pin_path_sel: assert property (rdy_q |->
    direct_bit_data_oe == $past(pin_oe_w)) else $error("data pin enable wrong");
endmodule : rbc_regs_chk
bind rbc_regs rbc_regs_chk i_chk (.clk_sys, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .bit_tick, .rx_bit_valid, .auto_synth_req, .auto_amp_req, .irq_req, .irq_pin_o,
  .irq_pin_oe, .direct_bit_data_oe, .synth_div, .radio, .eof_event);

// ---- tb/rbc_regs_tb.sv ----
// self-checking bench of the radio control bank
`timescale 1ns/1ps
`include "rbc_consts.svh"
module rbc_regs_tb;
  import rbc_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr, reg_rd, bit_tick, rx_bit, rx_bit_valid, auto_synth_req, auto_amp_req, irq_req;
  logic dbd_i, dbv_i, irq_pin_o, irq_pin_oe, dbd_oe, eof_event;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv, b;
  logic [11:0] tot;
  rbc_synth_s synth_div;
  rbc_radio_s radio;
  logic [15:0] seed_q = 16'hA382;
  int err_total = 0;
  int cmp_count = 0;
  int eofs = 0;
  logic [7:0] sent_q[$];
  logic [5:0] ra[6] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06};
  logic [7:0] rst_v[6] = '{8'h00, 8'h4A, 8'h00, 8'h00, 8'h01, 8'h03};
  logic [7:0] msk[6] = '{8'h1F, 8'h7F, 8'hFF, 8'h07, 8'h1B, 8'h0F};
  logic [7:0] wv[6];
  logic [2:0] rate_ok[4] = '{3'h0, 3'h4, 3'h5, 3'h6};
  always #12.5 clk_sys = ~clk_sys;
  rbc_host_model i_host (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
  rbc_regs #(.FIFO_DEPTH(8)) i_dut (.clk_sys, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .bit_tick, .rx_bit, .rx_bit_valid, .tx_bit(), .tx_bit_valid(), .auto_synth_req,
    .auto_amp_req, .irq_req, .irq_pin_o, .irq_pin_oe, .direct_bit_data_i(dbd_i),
    .direct_bit_data_o(), .direct_bit_data_oe(dbd_oe), .direct_bit_valid_i(dbv_i),
    .direct_bit_valid_o(), .direct_bit_valid_oe(), .synth_div, .radio, .eof_event);
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return s[0] ? (s >> 1) ^ 16'hB400 : s >> 1;
  endfunction : lfsr
  function automatic logic [1:0] irq_exp(input logic [1:0] sty, input logic r);
    return sty[1] ? {r, r & sty[0]} : {1'b1, r ~^ sty[0]};
  endfunction : irq_exp
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input logic v, input logic d);
    {bit_tick, rx_bit_valid, rx_bit, dbv_i, dbd_i} <= {1'b1, v, d, v, d};
    @(posedge clk_sys);
    {bit_tick, rx_bit_valid, rx_bit} <= {1'b0, ~v, ~d};
    repeat (4) begin
      #1 eofs += (eof_event === 1'b1);
      @(posedge clk_sys);
    end
  endtask : tick
  task automatic send(input logic [7:0] d, input int n);
    for (int i = 0; i < n; i++) tick(1'b1, d[i]);
  endtask : send
  task automatic end_sim;
    $display("checks %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    end_sim();
  end
  initial begin
    {bit_tick, rx_bit, rx_bit_valid, auto_synth_req, auto_amp_req, irq_req, dbd_i, dbv_i} = 8'h00;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    foreach (ra[i]) begin
      i_host.rd(ra[i], rv);
      chk(rv, rst_v[i]);
    end
    $display("reset values done");
    repeat (6) begin
      seed_q = lfsr(seed_q);
      {irq_req, auto_amp_req, auto_synth_req} <= seed_q[10:8];
      for (int i = 2; i < 6; i++) begin
        seed_q = lfsr(seed_q);
        wv[i] = (i == 3) ? {5'h00, rate_ok[seed_q[1:0]]} : seed_q[7:0] & msk[i];
        i_host.wr(ra[i], wv[i]);
        i_host.rd(ra[i], rv);
        chk(rv, wv[i]);
      end
      chk({radio.rx_mode, radio.tx_mode, radio.code32}, {wv[2][7:6], wv[3][2]});
      chk({radio.synth_on, radio.amp_on}, {wv[2][1] ? wv[2][0] : auto_synth_req,
        wv[2][3] ? wv[2][2] : auto_amp_req});
    end
    i_host.wr(6'h3E, 8'hFF);
    i_host.rd(6'h3E, rv);
    chk(rv, 8'h00);
    $display("register readback done");
    repeat (4) begin
      seed_q = lfsr(seed_q);
      i_host.wr(`RBC_ADDR_CHANNEL, {1'b0, seed_q[6:0]});
      tot = `RBC_SYNTH_BASE + {5'h00, seed_q[6:0]};
      i_host.rd(`RBC_ADDR_SYNTH_N, rv);
      chk(rv, {1'b0, tot[11:5]});
      i_host.rd(`RBC_ADDR_SYNTH_A, rv);
      chk(rv, {3'h0, tot[4:0]});
    end
    i_host.wr(`RBC_ADDR_CHANNEL, 8'h80);
    rv = {3'h0, seed_q[12:8]};
    b = seed_q[14] ? 8'h4C : 8'h4A + {7'h00, seed_q[13]};
    i_host.wr(`RBC_ADDR_SYNTH_A, rv);
    i_host.wr(`RBC_ADDR_SYNTH_N, b);
    #1 chk(synth_div, {b[6:0], rv[4:0]});
    $display("synthesizer source done");
    for (int s = 0; s < 8; s++) begin
      i_host.wr(`RBC_ADDR_CONFIG, {6'h00, s[2:1]});
      irq_req <= s[0];
      repeat (2) @(posedge clk_sys);
      #1 chk({irq_pin_oe, irq_pin_oe & irq_pin_o}, irq_exp(s[2:1], s[0]));
      @(posedge clk_sys);
    end
    $display("irq styles done");
    i_host.wr(`RBC_ADDR_CONFIG, 8'h11);
    i_host.wr(`RBC_ADDR_CONTROL, 8'h80);
    for (int len = 0; len < 4; len += 2) begin
      i_host.wr(`RBC_ADDR_SER_CTL, 8'h08 | len[7:0]);
      seed_q = lfsr(seed_q);
      eofs = 0;
      send(seed_q[7:0], 8);
      for (int i = 0; i <= len; i++) tick(1'b0, 1'b0);
      chk(16'(eofs), 16'h1);
      i_host.rd(`RBC_ADDR_RX_VALID, rv);
      chk(rv, 8'hFF);
      i_host.rd(`RBC_ADDR_RX_DATA, rv);
      b = ~seed_q[7:0];
      chk(rv, b);
      eofs = 0;
      send(seed_q[15:8], 3);
      for (int i = 0; i < len; i++) tick(1'b0, 1'b0);
      chk(16'(eofs), 16'h0);
      tick(1'b0, 1'b0);
      chk(16'(eofs), 16'h1);
      i_host.rd(`RBC_ADDR_RX_VALID, rv);
      chk(rv, 8'h07);
      i_host.rd(`RBC_ADDR_RX_DATA, rv);
      b = ~seed_q[15:8] & 8'h07;
      chk(rv & 8'h07, b);
    end
    $display("frame end done");
    i_host.wr(`RBC_ADDR_SER_CTL, 8'h0F);
    repeat (9) begin
      seed_q = lfsr(seed_q);
      sent_q.push_back(~seed_q[7:0]);
      send(seed_q[7:0], 8);
    end
    i_host.rd(`RBC_ADDR_RX_STATUS, rv);
    chk(rv & 8'h05, 8'h05);
    repeat (8) begin
      i_host.rd(`RBC_ADDR_RX_DATA, rv);
      chk(rv, sent_q.pop_front());
    end
    i_host.rd(`RBC_ADDR_RX_STATUS, rv);
    chk(rv & 8'h05, 8'h00);
    i_host.rd(`RBC_ADDR_RX_DATA, rv);
    i_host.rd(`RBC_ADDR_RX_STATUS, rv);
    chk(rv & 8'h04, 8'h04);
    $display("buffer fill and drain done");
    i_host.wr(`RBC_ADDR_SER_CTL, 8'h03);
    repeat (2) @(posedge clk_sys);
    #1 chk(dbd_oe, 1'b1);
    @(posedge clk_sys);
    send(seed_q[7:0], 2);
    $display("bit-serial path done");
    end_sim();
  end
endmodule : rbc_regs_tb
